/* shared/hcm_consts.svh */
// Offsets, field positions, reset values and timing counts of the
// calibration / one-time-memory / monitor register group.
// Assumes a 25 MHz system clock; included by its bare name.
`ifndef HCM_CONSTS_SVH
`define HCM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HCM_ADDR_CTRL        8'h1E
`define HCM_ADDR_SUPPLY      8'h21
`define HCM_ADDR_PERIOD      8'h22
`define HCM_ADDR_CFG_FIRST   8'h16
`define HCM_ADDR_CFG_LAST    8'h1A

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define HCM_BIT_LAUNCH       0
`define HCM_BIT_PROGRAMMED   2
`define HCM_CAL_LSB          4
`define HCM_CAL_MSB          5
`define HCM_CAL_RESET        2'h2
`define HCM_WRITE_MASK       8'h31

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HCM_CLK_MHZ          25
`define HCM_CAL0_MS          150
`define HCM_CAL1_MS          250
`define HCM_CAL2_MS          500
`define HCM_CAL3_MS          1000
`define HCM_MS_CYCLES(ms)    ((ms) * 1000 * `HCM_CLK_MHZ)

`endif

/* shared/hcm_pkg.sv */
// Types shared by the register group and its surroundings.
// Assumes hcm_consts.svh for all numeric values.
`default_nettype none
package hcm_pkg;

   // Register write strobe with address and data
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } hcm_wr_type;

   // One-time-memory programming sequencer states
   typedef enum logic [1:0] {
      HCM_IDLE = 2'b00,
      HCM_BURN = 2'b01,
      HCM_DONE = 2'b10
   } hcm_otp_type;

endpackage : hcm_pkg
`default_nettype wire

/* hdl/hcm_regs.sv */
// Calibration time, one-time-memory launch/status and live monitor regs.
// Assumes an upstream serial-bus decoder giving one-cycle write strobes and
// a combinational read address on clk_sys; the memory macro and analog
// measurement sit outside and talk over plain ports on the same clock.
//
// Contract
// - Two-bit calibration time, default code two
// - Bit two reads one once memory programmed
// - Launch bit copies 0x16-0x1A into memory
// - Memory programs once; later launches ignored
// - Supply reading, code times 5.6/255, playing only
// - Period code times 98.46us, updated playing only
`timescale 1ns/1ps
`default_nettype none
`include "hcm_consts.svh"

module hcm_regs #(
   parameter int CAL0_CYC = `HCM_MS_CYCLES(`HCM_CAL0_MS), // Long: shorten
   parameter int CAL1_CYC = `HCM_MS_CYCLES(`HCM_CAL1_MS),
   parameter int CAL2_CYC = `HCM_MS_CYCLES(`HCM_CAL2_MS),
   parameter int CAL3_CYC = `HCM_MS_CYCLES(`HCM_CAL3_MS)
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire hcm_pkg::hcm_wr_type bus_wr,
   input  wire logic [7:0]         bus_rd_addr,
   output logic [7:0]              bus_rd_data,
   input  wire logic               otp_blown,
   output logic                    otp_burn_req,
   output logic [2:0]              otp_burn_idx,
   input  wire logic               otp_burn_ack,
   input  wire logic               wave_active,
   input  wire logic [7:0]         supply_sample,
   input  wire logic [7:0]         period_sample,
   input  wire logic               cal_start,
   output logic                    cal_busy,
   output logic [31:0]             cal_cycles
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [1:0]          cal_time_ff, nxt_cal_time;     // Duration code
   logic                programmed_ff, nxt_programmed; // Memory state
   hcm_pkg::hcm_otp_type otp_ff, nxt_otp;              // Sequencer
   logic [2:0]          idx_ff, nxt_idx;               // Register index
   logic [7:0]          supply_ff, nxt_supply;         // Supply code
   logic [7:0]          period_ff, nxt_period;         // Period code
   logic [31:0]         cal_cnt_ff, nxt_cal_cnt;       // Calibration timer
   logic                cal_busy_ff, nxt_cal_busy;
   logic                blown_s1_ff, blown_s2_ff;      // Strap sync
   logic [1:0]          settle_ff, nxt_settle;         // Edges since reset
   logic                launch;

   // Cycles for each duration code; minimum of the window is used
   function automatic logic [31:0] cal_len(input logic [1:0] code);
      unique case (code)
         2'h0: cal_len = 32'(CAL0_CYC);
         2'h1: cal_len = 32'(CAL1_CYC);
         2'h2: cal_len = 32'(CAL2_CYC);
         2'h3: cal_len = 32'(CAL3_CYC);
      endcase
   endfunction : cal_len

   // Strobe passed in, so a continuous assign re-evaluates on every change
   function automatic logic hit(input hcm_pkg::hcm_wr_type w,
                                input logic [7:0]          a);
      hit = w.wr && (w.addr == a);
   endfunction : hit

   assign launch = hit(bus_wr, `HCM_ADDR_CTRL)
                   && bus_wr.data[`HCM_BIT_LAUNCH];

   // Fuse state pin comes from the memory macro, so synchronise it
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         blown_s1_ff <= 1'b0;
         blown_s2_ff <= 1'b0;
      end else begin
         blown_s1_ff <= otp_blown;
         blown_s2_ff <= blown_s1_ff;
      end
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      nxt_cal_time   = cal_time_ff;
      nxt_programmed = programmed_ff | blown_s2_ff;
      nxt_otp        = otp_ff;
      nxt_idx        = idx_ff;
      nxt_supply     = supply_ff;
      nxt_period     = period_ff;
      nxt_cal_cnt    = cal_cnt_ff;
      nxt_cal_busy   = cal_busy_ff;
      // Count two edges after reset; saturates once fuse sync is valid
      nxt_settle     = (settle_ff == 2'h2) ? settle_ff : settle_ff + 2'h1;
      // Only the duration field is writable; other bits dropped
      if (hit(bus_wr, `HCM_ADDR_CTRL)) begin
         nxt_cal_time = bus_wr.data[`HCM_CAL_MSB:`HCM_CAL_LSB];
      end
      // Monitors sample only while a waveform plays
      if (wave_active) begin
         nxt_supply = supply_sample;
         nxt_period = period_sample;
      end
      // Calibration timer runs the selected duration
      if (cal_busy_ff) begin
         if (cal_cnt_ff <= 32'h1) begin
            nxt_cal_busy = 1'b0;
         end
         nxt_cal_cnt = cal_cnt_ff - 32'h1;
      end else if (cal_start) begin
         nxt_cal_busy = 1'b1;
         nxt_cal_cnt  = cal_len(cal_time_ff);
      end
      // Programming sequencer: one pass per lifetime
      unique case (otp_ff)
         hcm_pkg::HCM_IDLE: begin
            // Wait for the fuse sync to settle, else a launch right
            // after reset could burn an already blown memory
            if (launch && settle_ff == 2'h2
                && !programmed_ff && !blown_s2_ff) begin
               nxt_otp = hcm_pkg::HCM_BURN;
               nxt_idx = 3'h0;
            end
         end
         hcm_pkg::HCM_BURN: begin
            if (otp_burn_ack) begin
               if (idx_ff == 3'(`HCM_ADDR_CFG_LAST - `HCM_ADDR_CFG_FIRST))
               begin
                  nxt_otp        = hcm_pkg::HCM_DONE;
                  nxt_programmed = 1'b1;
               end else begin
                  nxt_idx = idx_ff + 3'h1;
               end
            end
         end
         hcm_pkg::HCM_DONE: begin
            nxt_otp = hcm_pkg::HCM_DONE;
         end
         default: nxt_otp = hcm_pkg::HCM_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cal_time_ff   <= `HCM_CAL_RESET;
         programmed_ff <= 1'b0;
         otp_ff        <= hcm_pkg::HCM_IDLE;
         idx_ff        <= 3'h0;
         supply_ff     <= 8'h00;
         period_ff     <= 8'h00;
         cal_cnt_ff    <= 32'h0;
         cal_busy_ff   <= 1'b0;
         settle_ff     <= 2'h0;
      end else begin
         cal_time_ff   <= nxt_cal_time;
         programmed_ff <= nxt_programmed;
         otp_ff        <= nxt_otp;
         idx_ff        <= nxt_idx;
         supply_ff     <= nxt_supply;
         period_ff     <= nxt_period;
         cal_cnt_ff    <= nxt_cal_cnt;
         cal_busy_ff   <= nxt_cal_busy;
         settle_ff     <= nxt_settle;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign otp_burn_req = (otp_ff == hcm_pkg::HCM_BURN);
   // Index 0 means register 0x16, index 4 means 0x1A
   assign otp_burn_idx = idx_ff;
   assign cal_busy     = cal_busy_ff;
   assign cal_cycles   = cal_cnt_ff;

   // Read mux; reserved bits and unmapped addresses read zero
   always_comb begin
      bus_rd_data = 8'h00;
      unique case (bus_rd_addr)
         `HCM_ADDR_CTRL: begin
            bus_rd_data[`HCM_CAL_MSB:`HCM_CAL_LSB] = cal_time_ff;
            bus_rd_data[`HCM_BIT_PROGRAMMED] = programmed_ff;
         end
         `HCM_ADDR_SUPPLY: bus_rd_data = supply_ff;
         `HCM_ADDR_PERIOD: bus_rd_data = period_ff;
         default: bus_rd_data = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_cal_reset_two: assert property (@(posedge clk_sys)
      $rose(rst_b) |-> cal_time_ff == 2'h2)
      else $error("Calibration code not two after reset");
   a_cal_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_b)
      hit(bus_wr, `HCM_ADDR_CTRL)
      |=> cal_time_ff == $past(bus_wr.data[5:4]))
      else $error("Calibration code write lost");
   a_prog_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
      programmed_ff |=> programmed_ff)
      else $error("Programmed status fell");
   a_launch_starts: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (launch && otp_ff == hcm_pkg::HCM_IDLE && !programmed_ff
       && !blown_s2_ff && settle_ff == 2'h2)
      |=> otp_burn_req && otp_burn_idx == 3'h0)
      else $error("Launch did not start programming");
   a_early_launch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      launch && settle_ff != 2'h2 |=> !otp_burn_req)
      else $error("Launch taken before fuse state settled");
   a_once_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
      programmed_ff && otp_ff != hcm_pkg::HCM_BURN |=> !otp_burn_req)
      else $error("Memory programmed a second time");
   a_supply_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !wave_active |=> $stable(supply_ff))
      else $error("Supply reading moved while idle");
   a_period_track: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wave_active |=> period_ff == $past(period_sample))
      else $error("Period reading not updated");
   a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bus_rd_addr == `HCM_ADDR_CTRL |-> (bus_rd_data & 8'hCB) == 8'h00)
      else $error("Reserved control bits not zero");

endmodule : hcm_regs
`default_nettype wire

/* verification/hcm_otp_model.sv */
// Behavioural model of the one-time memory macro beside the register group.
// Assumes it shares clk_sys and rst_b with the register group.
`timescale 1ns/1ps
`default_nettype none

module hcm_otp_model (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       otp_burn_req,
   input  wire logic [2:0] otp_burn_idx,
   output logic            otp_burn_ack,
   output logic            otp_blown,
   output logic [3:0]      burnt,
   output logic            seq_err
);
   logic [2:0] wait_cnt;           // Cycles spent on the current index
   logic [3:0] burnt_q   = 4'h0;   // Bytes burnt; fuses keep it
   logic       blown_q   = 1'b0;   // Fuse state; survives rst_b
   logic       seq_err_q = 1'b0;   // Order fault seen; survives rst_b
   logic       take;               // This edge answers the request

   assign take      = otp_burn_req && !otp_burn_ack
                      && (wait_cnt >= otp_burn_idx);
   assign burnt     = burnt_q;
   assign otp_blown = blown_q;
   assign seq_err   = seq_err_q;

   // ----------------------------------------------------------------
   // Burn engine
   // ----------------------------------------------------------------
   // Acks after idx+1 cycles, so both prompt and slow answers are seen
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         otp_burn_ack <= 1'b0;
         wait_cnt     <= 3'h0;
      end else begin
         otp_burn_ack <= 1'b0;
         // Answer only while asked; one pulse per index
         if (take) begin
            otp_burn_ack <= 1'b1;
            wait_cnt     <= 3'h0;
         end else if (otp_burn_req && !otp_burn_ack) begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end

   // Fuses are nonvolatile: a reset must not clear what was burnt
   always @(posedge clk_sys) begin
      if (rst_b && take) begin
         burnt_q <= burnt_q + 4'h1;
         // Indices must come 0..4 in order, never a sixth
         if (otp_burn_idx !== burnt_q[2:0]) seq_err_q <= 1'b1;
         // Fuses read as blown once the last byte lands
         if (burnt_q == 4'h4) blown_q <= 1'b1;
      end
   end
endmodule : hcm_otp_model
`default_nettype wire

/* verification/tb_haptic_cal_otp_monitor_regs.sv */
// Self-checking bench for the calibration / memory / monitor registers.
// Assumes a 25 MHz clock and shortened calibration counts.
`timescale 1ns/1ps
`default_nettype none
`include "hcm_consts.svh"

module tb_haptic_cal_otp_monitor_regs;
   localparam int CYC [4] = '{10, 20, 40, 80}; // Short calibration counts
   logic clk_sys = 1'b0, rst_b = 1'b0, wave_active = 1'b0, cal_start = 1'b0;
   logic otp_burn_req, otp_burn_ack, otp_blown, cal_busy, seq_err;
   logic [2:0] otp_burn_idx;
   logic [3:0] burnt;
   logic [7:0] bus_rd_addr = 8'h00, bus_rd_data;
   logic [7:0] supply_sample = 8'h00, period_sample = 8'h00, v, pe;
   logic [31:0] cal_cycles, seed = 32'h2D5B;
   hcm_pkg::hcm_wr_type bus_wr = '0;
   int miscompares = 0, comparisons = 0, n;

   always #20 clk_sys = ~clk_sys;

   hcm_regs #(.CAL0_CYC(CYC[0]), .CAL1_CYC(CYC[1]), .CAL2_CYC(CYC[2]),
      .CAL3_CYC(CYC[3])) dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .bus_wr(bus_wr), .bus_rd_addr(bus_rd_addr), .bus_rd_data(bus_rd_data),
      .otp_blown(otp_blown), .otp_burn_req(otp_burn_req),
      .otp_burn_idx(otp_burn_idx), .otp_burn_ack(otp_burn_ack),
      .wave_active(wave_active), .supply_sample(supply_sample),
      .period_sample(period_sample), .cal_start(cal_start),
      .cal_busy(cal_busy), .cal_cycles(cal_cycles));

   hcm_otp_model otp (.clk_sys(clk_sys), .rst_b(rst_b),
      .otp_burn_req(otp_burn_req), .otp_burn_idx(otp_burn_idx),
      .otp_burn_ack(otp_burn_ack), .otp_blown(otp_blown), .burnt(burnt),
      .seq_err(seq_err));

   // Next random word; taps keep the sequence long
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One-cycle write strobe, launched and dropped at falling edges
   task automatic wr(input logic [7:0] a, d);
      bus_wr = '{wr: 1'b1, addr: a, data: d};
      @(negedge clk_sys);
      bus_wr.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, exp);
      bus_rd_addr = a;
      #1 chk("rd_data", {24'h0, exp}, {24'h0, bus_rd_data});
   endtask : rd

   task tally_and_finish;
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // Generous bound: the whole sequence needs well under 2000 cycles
   initial begin
      #(40 * 20000);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      rd(`HCM_ADDR_CTRL, 8'h20);
      rd(`HCM_ADDR_SUPPLY, 8'h00);
      rd(`HCM_ADDR_PERIOD, 8'h00);
      // Random control writes, launch bit clear; supply monitor refuses writes
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v = seed[7:0] & 8'hFE;
         wr(`HCM_ADDR_CTRL, v);
         rd(`HCM_ADDR_CTRL, v & 8'h30);
         wr(`HCM_ADDR_SUPPLY, v);
         rd(`HCM_ADDR_SUPPLY, 8'h00);
      end
      // Each calibration code loads its own length
      for (int c = 0; c < 4; c++) begin
         wr(`HCM_ADDR_CTRL, 8'(c << 4));
         cal_start = 1'b1;
         @(negedge clk_sys);
         cal_start = 1'b0;
         chk("cal_busy", 1, cal_busy);
         chk("cal_cycles", CYC[c], cal_cycles);
         n = 0;
         // A restart pulse while busy must be refused
         while (cal_busy === 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
            cal_start = (n == 2);
         end
         chk("cal_len", CYC[c], n);
      end
      // Monitors follow samples while playing, hold when idle
      v = 8'h00;
      pe = 8'h00;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         // First two passes force idle then playing
         wave_active = (i < 2) ? (i == 1) : seed[8];
         if (wave_active === 1'b1) begin
            v = seed[7:0];
            pe = ~seed[7:0];
         end
         supply_sample = seed[7:0];
         period_sample = ~seed[7:0];
         @(negedge clk_sys);
         supply_sample = seed[15:8];
         period_sample = seed[23:16];
         rd(`HCM_ADDR_SUPPLY, v);
         rd(`HCM_ADDR_PERIOD, pe);
      end
      wave_active = 1'b0;
      // Launch programming, then try again once programmed
      wr(`HCM_ADDR_CTRL, 8'h21);
      chk("burn_req", 1, otp_burn_req);
      chk("burn_idx", 0, otp_burn_idx);
      n = 0;
      while (otp_burn_req === 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (3) @(negedge clk_sys);
      chk("burnt", 5, burnt);
      rd(`HCM_ADDR_CTRL, 8'h24);
      wr(`HCM_ADDR_CTRL, 8'h21);
      repeat (3) @(negedge clk_sys);
      chk("burn_req_again", 0, otp_burn_req);
      chk("burnt_again", 5, burnt);
      chk("seq_err", 0, seq_err);
      // Power cycle: fuses keep their state, status returns after sync
      rst_b = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      rd(`HCM_ADDR_CTRL, 8'h20);
      wr(`HCM_ADDR_CTRL, 8'h21);
      chk("burn_req_boot", 0, otp_burn_req);
      repeat (2) @(negedge clk_sys);
      rd(`HCM_ADDR_CTRL, 8'h24);
      chk("burnt_boot", 5, burnt);
      chk("seq_err_boot", 0, seq_err);
      tally_and_finish();
   end
endmodule : tb_haptic_cal_otp_monitor_regs
`default_nettype wire
